// *** pcc_cpl_sender.sv ***
// Purpose: User-side engine that sends completion packets to the core.
// Assumes: Job fields are stable while job_valid is high; job_kind and job_abort until job_done.
// Notes:   One packet at a time; payload Dwords are pre-padded by caller.
//
// Function
// - One completion per non-posted request received.
// - Good requests complete with successful status.
// - Oversize data split, each with descriptor; not done here, each job is sent as one packet of at most MAX_DW payload Dwords.
// - Dword mode: payload follows descriptor directly.
// - Null bytes pad payload to Dwords.
// - Non-contiguous bytes placed in lanes, gaps null.
// - Valid held high through whole packet.
// - Last asserted only on final beat.
// - Outputs frozen while ready is low.
// - Address mode: payload starts next beat.
// - Memory-read payload on address lane, else zero.
// - Discontinue during payload aborts the completion.
// - Discontinue only with valid, held until ready.
// - Error completions carry eight Dwords total.
// - Fourth Dword holds enables and hint fields.
// - Dwords five to eight copy request descriptor.
// - Error packet beats: four, two, one.
`default_nettype none
module pcc_cpl_sender
    import pcc_pkg::*;
#(
    parameter int DATA_W   = 64,
    parameter int MAX_DW   = 16,
    parameter bit ADDR_ALN = 1'b0
) (
    input  wire logic                    clk_sys,
    input  wire logic                    reset,
    input  wire logic                    job_valid,
    output logic                         job_ready,
    input  wire logic [1:0]              job_kind,
    input  wire logic [95:0]             job_desc,
    input  wire logic [18:0]             job_req_info,
    input  wire logic [127:0]            job_req_desc,
    input  wire logic [PCC_CNT_W-1:0]    job_pay_dw,
    input  wire logic [4:0]              job_addr_lo,
    input  wire logic [MAX_DW*32-1:0]    job_payload,
    input  wire logic                    job_abort,
    output logic                         job_done,
    output logic                         job_aborted,
    output logic [DATA_W-1:0]            cpl_in_data,
    output logic                         cpl_in_valid,
    input  wire logic                    cpl_in_ready,
    output logic                         cpl_in_last,
    output logic [PCC_SB_W-1:0]          cpl_in_sideband
);
    localparam int LANES = DATA_W / PCC_DW_BITS;
    localparam int DEPTH = PCC_ERR_TOTAL_DW + MAX_DW;
    localparam int IDX_W = $clog2(DEPTH + LANES + 1);

    initial begin
        if (!(DATA_W == 64 || DATA_W == 128 || DATA_W == 256)) begin
            $error("Unsupported data path width.");
        end
    end

    pcc_state_t              state_q, state_d;
    logic [DEPTH*32-1:0]     words_q, words_d;
    logic [IDX_W-1:0]        idx_q, idx_d;
    logic [IDX_W-1:0]        end_q, end_d;
    logic [IDX_W-1:0]        split_q, split_d;
    logic [IDX_W-1:0]        off_q, off_d;
    logic                    disc_q, disc_d;
    logic                    aborted_q, aborted_d;
    logic                    done_q, done_d;
    logic [DATA_W-1:0]       data_q, data_d;
    logic                    last_q, last_d;
    logic [IDX_W-1:0]        adv_q, adv_d;
    logic [DATA_W-1:0]       pk_data;
    logic [IDX_W-1:0]        pk_used;
    logic [IDX_W-1:0]        pk_first;
    logic [IDX_W-1:0]        pk_off;
    logic [IDX_W-1:0]        pk_end;
    logic                    beat_go;
    logic                    err_kind;

    assign beat_go  = cpl_in_valid && cpl_in_ready;
    assign err_kind = (job_kind == PCC_KIND_ERR);

    pcc_beat_pack #(
        .LANES (LANES),
        .DEPTH (DEPTH),
        .IDX_W (IDX_W)
    ) u_pack (
        .pkt_words (words_d),
        .first_idx (pk_first),
        .lane_off  (pk_off),
        .end_idx   (pk_end),
        .beat_data (pk_data),
        .used_dw   (pk_used)
    );

    // Packet image: descriptor, then either error words or payload.
    function automatic logic [DEPTH*32-1:0] build_words();
        logic [DEPTH*32-1:0] w;
        logic [31:0]         info;
        w = '0;
        w[95:0] = job_desc;
        if (err_kind) begin
            info = 32'h0000_0000;
            info[18:0] = job_req_info;
            w[127:96]  = info;
            w[255:128] = job_req_desc;
        end else begin
            w[96 +: MAX_DW*32] = job_payload;
        end
        return w;
    endfunction

    always_comb begin
        state_d   = state_q;
        words_d   = words_q;
        idx_d     = idx_q;
        end_d     = end_q;
        split_d   = split_q;
        off_d     = off_q;
        disc_d    = disc_q;
        aborted_d = aborted_q;
        data_d    = data_q;
        last_d    = last_q;
        adv_d     = adv_q;
        done_d    = 1'b0;
        job_ready = 1'b0;
        pk_first  = idx_q;
        pk_off    = '0;
        pk_end    = end_q;
        case (state_q)
            PCC_IDLE: begin
                job_ready = 1'b1;
                if (job_valid) begin
                    words_d   = build_words();
                    aborted_d = 1'b0;
                    disc_d    = 1'b0;
                    if (err_kind) begin
                        end_d   = IDX_W'(PCC_ERR_TOTAL_DW);
                        split_d = IDX_W'(PCC_ERR_TOTAL_DW);
                    end else begin
                        end_d   = IDX_W'(PCC_DESC_DW) +
                                  IDX_W'(job_pay_dw);
                        split_d = (ADDR_ALN && job_pay_dw != '0) ?
                                  IDX_W'(PCC_DESC_DW) : end_d;
                    end
                    off_d    = (ADDR_ALN && job_kind == PCC_KIND_MRD) ?
                               IDX_W'(job_addr_lo[1:0] & 2'(LANES - 1)) :
                               '0;
                    if (LANES == 8) begin
                        off_d = (ADDR_ALN && job_kind == PCC_KIND_MRD) ?
                                IDX_W'(job_addr_lo[2:0]) : '0;
                    end
                    pk_first = '0;
                    pk_off   = '0;
                    pk_end   = split_d;
                    data_d   = pk_data;
                    adv_d    = pk_used;
                    last_d   = (pk_used >= end_d);
                    idx_d    = '0;
                    state_d  = PCC_SEND;
                end
            end
            PCC_SEND: begin
                if (beat_go) begin
                    if (cpl_in_sideband[PCC_SB_DISC_BIT]) begin
                        aborted_d = 1'b1;
                    end
                    disc_d = 1'b0;
                    if (cpl_in_last) begin
                        done_d  = 1'b1;
                        state_d = PCC_IDLE;
                    end else begin
                        idx_d = idx_q + adv_q;
                        if (idx_q + adv_q >= split_q) begin
                            pk_off  = off_q;
                            pk_end  = end_q;
                            split_d = end_q;
                        end else begin
                            pk_off = '0;
                            pk_end = split_q;
                        end
                        pk_first = idx_q + adv_q;
                        data_d   = pk_data;
                        adv_d    = pk_used;
                        // Abort lands on the first beat after the opening beat that carries payload.
                        disc_d   = job_abort && !err_kind &&
                                   (pk_first + pk_used >
                                    IDX_W'(PCC_DESC_DW));
                        last_d   = (pk_first + pk_used >= end_q) ||
                                   disc_d;
                    end
                end
            end
            default: begin
                state_d = PCC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_q   <= PCC_IDLE;
            words_q   <= '0;
            idx_q     <= '0;
            end_q     <= '0;
            split_q   <= '0;
            off_q     <= '0;
            disc_q    <= 1'b0;
            aborted_q <= 1'b0;
            done_q    <= 1'b0;
            data_q    <= '0;
            last_q    <= 1'b0;
            adv_q     <= '0;
        end else begin
            state_q   <= state_d;
            words_q   <= words_d;
            idx_q     <= idx_d;
            end_q     <= end_d;
            split_q   <= split_d;
            off_q     <= off_d;
            disc_q    <= disc_d;
            aborted_q <= aborted_d;
            done_q    <= done_d;
            data_q    <= data_d;
            last_q    <= last_d;
            adv_q     <= adv_d;
        end
    end

    // Valid stays high across the packet so the core never nullifies it for a gap in valid.
    assign cpl_in_valid = (state_q == PCC_SEND);
    assign cpl_in_data  = data_q;
    assign cpl_in_last  = last_q;
    always_comb begin
        cpl_in_sideband = '0;
        cpl_in_sideband[PCC_SB_DISC_BIT] = disc_q;
        cpl_in_sideband[PCC_SB_ALIGN_LSB +: PCC_SB_ALIGN_W] =
            ADDR_ALN ? 5'(off_q) : 5'h00;
    end
    assign job_done    = done_q;
    assign job_aborted = aborted_q;

    AST_HOLD_STALL: assert property (@(posedge clk_sys) disable iff (reset)
        cpl_in_valid && !cpl_in_ready |=> cpl_in_valid &&
        $stable(cpl_in_data) && $stable(cpl_in_last) &&
        $stable(cpl_in_sideband))
        else $error("Port changed while ready was low.");
    AST_VALID_GAP: assert property (@(posedge clk_sys) disable iff (reset)
        cpl_in_valid && !(cpl_in_ready && cpl_in_last) |=> cpl_in_valid)
        else $error("Valid dropped inside a packet.");
    AST_DISC_VALID: assert property (@(posedge clk_sys) disable iff (reset)
        cpl_in_sideband[PCC_SB_DISC_BIT] |-> cpl_in_valid)
        else $error("Discontinue without valid.");
    AST_DONE: assert property (@(posedge clk_sys) disable iff (reset)
        beat_go && cpl_in_last |=> job_done && !cpl_in_valid)
        else $error("Packet end not reported.");
    AST_STICKY: assert property (@(posedge clk_sys) disable iff (reset)
        beat_go && cpl_in_sideband[PCC_SB_DISC_BIT] |=>
        job_aborted)
        else $error("Abort not recorded.");
    AST_ERR_BEATS: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(cpl_in_valid) && err_kind && cpl_in_ready &&
        DATA_W == 256 |-> cpl_in_last)
        else $error("Error packet not one beat on wide port.");
    AST_LAST_END: assert property (@(posedge clk_sys) disable iff (reset)
        cpl_in_valid && cpl_in_last && !aborted_q &&
        !cpl_in_sideband[PCC_SB_DISC_BIT] |-> idx_q + adv_q >= end_q)
        else $error("Last raised before packet end.");
    AST_DESC_FIRST: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(cpl_in_valid) |-> cpl_in_data[31:0] == words_q[31:0])
        else $error("First beat does not start with descriptor.");
    AST_FIRST_IDX: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(cpl_in_valid) |-> idx_q == '0)
        else $error("Packet does not start at Dword zero.");
    AST_DISC_PAY: assert property (@(posedge clk_sys) disable iff (reset)
        cpl_in_sideband[PCC_SB_DISC_BIT] |->
        !err_kind && (idx_q + adv_q > IDX_W'(PCC_DESC_DW)))
        else $error("Discontinue outside a payload beat.");
    AST_ABORT_END: assert property (@(posedge clk_sys) disable iff (reset)
        beat_go && cpl_in_sideband[PCC_SB_DISC_BIT] |-> cpl_in_last)
        else $error("Aborted packet not ended on its discontinue beat.");
    AST_ERR_LEN: assert property (@(posedge clk_sys) disable iff (reset)
        beat_go && cpl_in_last && err_kind |->
        idx_q + adv_q == IDX_W'(PCC_ERR_TOTAL_DW))
        else $error("Error packet length is not eight Dwords.");
    AST_DONE_ONE: assert property (@(posedge clk_sys) disable iff (reset)
        job_done |=> !job_done)
        else $error("Done pulse longer than one cycle.");
    AST_READY_IDLE: assert property (@(posedge clk_sys) disable iff (reset)
        job_ready |-> !cpl_in_valid)
        else $error("New job offered while a packet is in flight.");
    AST_ABORT_CLR: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(cpl_in_valid) |-> !job_aborted)
        else $error("Abort flag carried into a new packet.");
endmodule : pcc_cpl_sender
`default_nettype wire

// *** pcc_pkg.sv ***
// Purpose: Constants for the completion packet sender.
// Assumes: Dword is 32 bits; descriptor is three Dwords.
// Notes:   Sideband layout below is a local convention.
`default_nettype none
package pcc_pkg;
    localparam int          PCC_DESC_DW      = 3;
    localparam int          PCC_ERR_EXTRA_DW = 5;
    localparam int          PCC_ERR_TOTAL_DW = 8;
    localparam int          PCC_DW_BITS      = 32;
    localparam int          PCC_MAX_DW       = 1024;
    localparam int          PCC_CNT_W        = 11;
    localparam int          PCC_SB_W         = 33;
    localparam int          PCC_SB_DISC_BIT  = 0;
    localparam int          PCC_SB_ALIGN_LSB = 1;
    localparam int          PCC_SB_ALIGN_W   = 5;
    localparam int          PCC_INFO_FBE_LSB = 0;
    localparam int          PCC_INFO_LBE_LSB = 4;
    localparam int          PCC_INFO_TPH_BIT = 8;
    localparam int          PCC_INFO_TYP_LSB = 9;
    localparam int          PCC_INFO_TAG_LSB = 11;
    localparam logic [1:0]  PCC_KIND_SC      = 2'h0;
    localparam logic [1:0]  PCC_KIND_ERR     = 2'h1;
    localparam logic [1:0]  PCC_KIND_MRD     = 2'h2;
    typedef enum logic [1:0] {
        PCC_IDLE = 2'b00,
        PCC_SEND = 2'b01
    } pcc_state_t;
endpackage : pcc_pkg
`default_nettype wire

// *** pcc_beat_pack.sv ***
// Purpose: Packs one beat of Dwords from a flat Dword array.
// Assumes: Index and lane offset are in range of the packet array.
// Notes:   Lanes below the offset or past the end are null bytes.
`default_nettype none
module pcc_beat_pack
    import pcc_pkg::*;
#(
    parameter int LANES  = 2,
    parameter int DEPTH  = 16,
    parameter int IDX_W  = 5
) (
    input  wire logic [DEPTH*32-1:0] pkt_words,
    input  wire logic [IDX_W-1:0]    first_idx,
    input  wire logic [IDX_W-1:0]    lane_off,
    input  wire logic [IDX_W-1:0]    end_idx,
    output logic      [LANES*32-1:0] beat_data,
    output logic      [IDX_W-1:0]    used_dw
);
    logic [LANES-1:0] lane_used;
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            logic [IDX_W-1:0] src;
            logic             live;
            assign live = (IDX_W'(g) >= lane_off) &&
                          ((first_idx + IDX_W'(g) - lane_off) < end_idx);
            assign src  = first_idx + IDX_W'(g) - lane_off;
            assign lane_used[g] = live;
            assign beat_data[g*32 +: 32] =
                live ? pkt_words[src*32 +: 32] : 32'h0000_0000;
        end
    endgenerate
    always_comb begin
        used_dw = '0;
        for (int i = 0; i < LANES; i++) begin
            used_dw = used_dw + IDX_W'(lane_used[i]);
        end
    end
endmodule : pcc_beat_pack
`default_nettype wire

// *** pcc_dev_model.sv ***
// Purpose: Device-side model of the completion input port.
// Assumes: 64-bit data path; discontinue is sideband bit 0.
// Notes:   Ready stalls at random while stall_en is high.
`default_nettype none
module pcc_dev_model
    import pcc_pkg::*;
(
    input  wire logic                clk_sys,
    input  wire logic                reset,
    input  wire logic                stall_en,
    input  wire logic                cpl_in_valid,
    input  wire logic                cpl_in_last,
    input  wire logic [PCC_SB_W-1:0] cpl_in_sideband,
    output logic                     cpl_in_ready,
    output logic                     pkt_nullified,
    output logic                     aer_internal_err,
    output logic [7:0]               pkt_beats
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       in_pkt;
    logic       disc_err;
    logic       gap_err;
    logic       disc_now;
    logic [7:0] beats;

    // Discontinue counts only on an accepted beat and stays set.
    assign disc_now = disc_err | cpl_in_sideband[0];

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cpl_in_ready     <= 1'b0;
            in_pkt           <= 1'b0;
            disc_err         <= 1'b0;
            gap_err          <= 1'b0;
            beats            <= 8'h00;
            pkt_nullified    <= 1'b0;
            aer_internal_err <= 1'b0;
            pkt_beats        <= 8'h00;
        end else begin
            cpl_in_ready <= stall_en ? ($urandom_range(3) != 0) : 1'b1;
            if (in_pkt && !cpl_in_valid) begin
                gap_err <= 1'b1;
            end
            if (cpl_in_valid && cpl_in_ready) begin
                if (cpl_in_last) begin
                    in_pkt           <= 1'b0;
                    disc_err         <= 1'b0;
                    gap_err          <= 1'b0;
                    beats            <= 8'h00;
                    pkt_nullified    <= disc_now | gap_err;
                    aer_internal_err <= disc_now;
                    pkt_beats        <= beats + 8'h01;
                end else begin
                    in_pkt   <= 1'b1;
                    disc_err <= disc_now;
                    beats    <= beats + 8'h01;
                end
            end
        end
    end
endmodule // pcc_dev_model
`default_nettype wire

// *** test_pcc_cpl_sender.sv ***
// Purpose: Self-checking bench for the completion packet sender.
// Assumes: Dword-aligned mode, 64-bit port, null bytes read as zero.
// Notes:   Expected beats come from a queue built per job.
`default_nettype none
module test_pcc_cpl_sender;
    import pcc_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int MAX_DW = 8;
    logic clk_sys = 1'b0, reset, stall_en, job_valid, job_ready, job_abort;
    logic job_done, job_aborted, cpl_in_valid, cpl_in_ready, cpl_in_last;
    logic [1:0] job_kind;
    logic [95:0] job_desc;
    logic [18:0] job_req_info;
    logic [127:0] job_req_desc;
    logic [PCC_CNT_W-1:0] job_pay_dw;
    logic [4:0] job_addr_lo;
    logic [MAX_DW*32-1:0] job_payload;
    logic [63:0] cpl_in_data, prv_data;
    logic [PCC_SB_W-1:0] cpl_in_sideband, prv_sb;
    logic nullified, aer_err, hold_q = 1'b0, prv_last, abort_run = 1'b0;
    logic [7:0] pkt_beats;
    logic [63:0] exp_q[$];
    int n_mismatch = 0, n_tests = 0, n_exp, t;

    pcc_cpl_sender #(.DATA_W(64), .MAX_DW(MAX_DW), .ADDR_ALN(1'b0))
        i_pcc_cpl_sender (.clk_sys, .reset, .job_valid, .job_ready,
        .job_kind, .job_desc, .job_req_info, .job_req_desc, .job_pay_dw,
        .job_addr_lo, .job_payload, .job_abort, .job_done, .job_aborted,
        .cpl_in_data, .cpl_in_valid, .cpl_in_ready, .cpl_in_last,
        .cpl_in_sideband);
    pcc_dev_model i_pcc_dev_model (.clk_sys, .reset, .stall_en,
        .cpl_in_valid, .cpl_in_last, .cpl_in_sideband, .cpl_in_ready,
        .pkt_nullified(nullified), .aer_internal_err(aer_err), .pkt_beats);

    always #4 clk_sys = ~clk_sys;

    task automatic check_val(input string nm, input logic [63:0] e, g);
        n_tests++;
        if (e !== g) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic check_bit(input string nm, input logic e, g);
        check_val(nm, {63'h0, e}, {63'h0, g});
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic wait_for(ref logic s);
        int k;
        k = 0;
        while (s !== 1'b1 && k < 300) begin
            @(negedge clk_sys);
            k++;
        end
        if (s !== 1'b1) begin
            n_mismatch++;
            end_of_test();
        end
    endtask

    // Builds the expected beats, offers one job and checks its outcome.
    task automatic run_job(input logic [1:0] kind, input int npay,
                           input logic abort);
        logic [31:0] w[$];
        int k;
        @(negedge clk_sys);
        if (kind == PCC_KIND_ERR) npay = 0;
        for (k = 0; k < 3; k++) job_desc[k*32+:32] = $urandom;
        for (k = 0; k < 4; k++) job_req_desc[k*32+:32] = $urandom;
        for (k = 0; k < MAX_DW; k++) job_payload[k*32+:32] = $urandom;
        job_req_info = 19'($urandom);
        job_addr_lo = 5'($urandom);
        job_kind = kind;
        job_abort = abort;
        job_pay_dw = PCC_CNT_W'(npay);
        for (k = 0; k < 3; k++) w.push_back(job_desc[k*32+:32]);
        if (kind == PCC_KIND_ERR) begin
            w.push_back({13'h0, job_req_info});
            for (k = 0; k < 4; k++) w.push_back(job_req_desc[k*32+:32]);
        end
        for (k = 0; k < npay; k++) w.push_back(job_payload[k*32+:32]);
        exp_q.delete();
        for (k = 0; k < w.size(); k += 2)
            exp_q.push_back({(k + 1 < w.size()) ? w[k+1] : 32'h0, w[k]});
        n_exp = exp_q.size();
        abort_run = abort;
        job_valid = 1'b1;
        wait_for(job_ready);
        @(negedge clk_sys);
        job_valid = 1'b0;
        wait_for(job_done);
        check_bit("nullified", abort, nullified);
        check_bit("aborted", abort, job_aborted);
        check_bit("aer", abort, aer_err);
        if (!abort) check_val("beats", 64'(n_exp), 64'(pkt_beats));
        $display("test kind %0d pay %0d abort %0d done", kind, npay, abort);
    endtask

    // Watches every accepted beat and every stalled cycle.
    always @(posedge clk_sys) begin
        if (!reset && cpl_in_valid && hold_q) begin
            check_val("held_data", prv_data, cpl_in_data);
            check_val("held_ctl", {30'h0, prv_last, prv_sb},
                      {30'h0, cpl_in_last, cpl_in_sideband});
        end
        if (!reset && cpl_in_valid && cpl_in_ready) begin
            if (exp_q.size() == 0) begin
                check_bit("extra_beat", 1'b0, 1'b1);
            end else begin
                check_val("beat", exp_q.pop_front(),
                          cpl_in_data);
                if (!abort_run)
                    check_bit("last", exp_q.size() == 0, cpl_in_last);
            end
            check_bit("disc", abort_run & cpl_in_last,
                      cpl_in_sideband[0]);
        end
        hold_q <= cpl_in_valid & ~cpl_in_ready;
        prv_data <= cpl_in_data;
        prv_last <= cpl_in_last;
        prv_sb <= cpl_in_sideband;
    end

    initial begin
        reset = 1'b1;
        stall_en = 1'b0;
        job_valid = 1'b0;
        job_abort = 1'b0;
        job_kind = 2'h0;
        job_desc = '0;
        job_req_info = '0;
        job_req_desc = '0;
        job_pay_dw = '0;
        job_addr_lo = 5'h00;
        job_payload = '0;
        void'($urandom(99));
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        reset = 1'b0;
        @(negedge clk_sys);
        check_bit("job_ready", 1'b1, job_ready);
        for (t = 0; t < 18; t++) begin
            stall_en = t[0];
            run_job(2'(t % 3), (t < 6) ? t : $urandom_range(MAX_DW, 1),
                    t >= 12 && (t % 3) != 1);
        end
        end_of_test();
    end
endmodule // test_pcc_cpl_sender
`default_nettype wire
